// *** inc/fbc_pkg.sv ***
// shared constants and types of the four-bit core
package fbc_pkg;
  localparam int PC_W = 10;
  localparam int ROM_WORDS = 1024;
  localparam int RAM_WORDS = 32;
  localparam int STACK_DEPTH = 4;
  // clock tree: core clock is hclk/8 until fast mode, machine cycle = core/4
  localparam logic [2:0] CORE_DIV_LAST = 3'h7;
  localparam logic [1:0] MC_DIV_LAST = 2'h3;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ROM_ADDR = 8'h04;
  localparam logic [7:0] OFS_ROM_DATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_PORT = 8'h10;
  localparam int CTRL_RUN_BIT = 0;
  // instruction classes in bits 8:7
  localparam logic [1:0] CL_BASIC = 2'h0;
  localparam logic [1:0] CL_P2CALL = 2'h1;
  localparam logic [1:0] CL_BRANCH = 2'h2;
  localparam logic [1:0] CL_CALL = 2'h3;
  // basic groups in bits 6:4
  localparam logic [2:0] G_MISC = 3'h0;
  localparam logic [2:0] G_ADDI = 3'h1;
  localparam logic [2:0] G_LDI = 3'h2;
  localparam logic [2:0] G_SKEQ = 3'h3;
  localparam logic [2:0] G_PTR = 3'h4;
  localparam logic [2:0] G_LDY = 3'h5;
  localparam logic [2:0] G_TABLE = 3'h6;
  localparam logic [2:0] G_CALLMEM = 3'h7;
  // misc operations in bits 3:0
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_ADD_WITH_CARRY = 4'h1;
  localparam logic [3:0] OP_ADD_MEMORY = 4'h2;
  localparam logic [3:0] OP_ROTATE_RIGHT = 4'h3;
  localparam logic [3:0] OP_CARRY_SET = 4'h4;
  localparam logic [3:0] OP_CARRY_CLEAR = 4'h5;
  localparam logic [3:0] OP_TABLE_MSB_SET = 4'h6;
  localparam logic [3:0] OP_FAST_CLOCK = 4'h7;
  localparam logic [3:0] OP_RETURN = 4'h8;
  localparam logic [3:0] OP_RETURN_SKIP = 4'h9;
  localparam logic [3:0] OP_PAIR_STORE = 4'ha;
  localparam logic [3:0] OP_PAIR_LOAD = 4'hb;
  localparam logic [3:0] OP_PORT_SET_BIT = 4'hc;
  localparam logic [3:0] OP_PORT_CLEAR_BIT = 4'hd;
  localparam logic [3:0] OP_PORT_TEST_BIT = 4'he;
  localparam logic [3:0] OP_PORT_CLEAR_ALL = 4'hf;
  // memory operations in bits 2:0 of group 7 with bit 3 set
  localparam logic [2:0] M_LOAD = 3'h0;
  localparam logic [2:0] M_STORE = 3'h1;
  localparam logic [2:0] M_XCHG = 3'h2;
  localparam logic [2:0] M_A_TO_B = 3'h3;
  localparam logic [2:0] M_B_TO_A = 3'h4;
  localparam logic [2:0] M_IN_G = 3'h5;
  localparam logic [2:0] M_IN_E = 3'h6;
  localparam logic [2:0] M_PULLDOWN = 3'h7;
  localparam logic [2:0] PAGE2 = 3'h2;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [1:0] SP_RESET = 2'h0;

  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_TABLE_READ = 3'b010,
    ST_SETTLE = 3'b100
  } fbc_state_type;

  typedef struct packed {
    logic       d7;
    logic [2:0] e;
    logic [3:0] g;
  } fbc_pins_type;

  typedef struct packed {
    logic [ROM_WORDS-1:0][8:0]      rom;
    logic [RAM_WORDS-1:0][3:0]      ram;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
    logic [PC_W-1:0]                pc;
    logic [PC_W-1:0]                rom_ptr;
    logic [1:0]                     sp;
    fbc_state_type                  state;
    logic [3:0]                     a;
    logic [3:0]                     b;
    logic [7:0]                     e;
    logic [2:0]                     d;
    logic                           x;
    logic [3:0]                     y;
    logic                           cy;
    logic                           table_msb_enable;
    logic                           skip;
    logic                           fast;
    logic                           run;
    logic [2:0]                     pre;
    logic [1:0]                     mcnt;
    logic                           mc_tick;
    logic [7:0]                     pd;
    logic [2:0]                     pu;
    logic                           wake;
    fbc_pins_type                   sync1;
    fbc_pins_type                   sync2;
    logic                           bk1;
    logic                           bk2;
    logic                           wr_pend;
    logic [7:0]                     wr_addr;
    logic [31:0]                    rdata;
    logic                           ready;
  } fbc_core_type;
endpackage

// *** hw/fbc_core.sv ***
// four-bit controller core with clock divider, stack, rom and ahb-lite slave
// What this block does
// - core clock is hclk/8, undivided once the fast clock op runs
// - machine cycle is core clock divided by four
// - four-bit alu adds, compares, moves bits around the accumulator
// - add with carry sets carry; add immediate and add memory keep it
// - rotate right moves accumulator bit 0 into carry
// - carry set op forces one, carry clear op forces zero
// - pair register holds b as upper nibble, a as lower nibble
// - page offset register and accumulator form a seven-bit in-page address
// - table fetch copies rom bit 8 to carry only when msb enable set
// - msb enable clears at reset and backup return, no software clear
// - calls and table fetch push the pc onto a four-entry stack
// - a two-bit stack index moves automatically on push and pop
// - page2 call with index 3 wraps to 0 and overwrites entry 0
// - a taken skip cancels the next instruction in one machine cycle
// - skipped table fetch or return takes one machine cycle
// - pc has page and seven-bit offset; 127 rolls to next page
// - branch, call, return, table fetch load pc instead of counting
// - ram pointer is file plus digit; digit picks the port bit
// - rom is eight pages of 128 nine-bit words, all readable as data
// - one-word page2 call reaches page 2 code from any page
// - pulldown control enables pulldown and wakeup on port inputs
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module fbc_core
  import fbc_pkg::*;
(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  input  wire fbc_pkg::fbc_pins_type pins_in,
  input  wire logic          backup_return,
  output logic [7:0]         port_d_out,
  output logic [2:0]         pulldown_en,
  output logic               wakeup,
  output logic               machine_cycle
);
  import fbc_pkg::*;

  fbc_core_type    r;
  fbc_core_type    n;
  logic [8:0]      ir;
  logic [8:0]      tword;
  logic [3:0]      mem;
  logic [4:0]      sum;
  logic [1:0]      sp_inc;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] in_page;
  logic [7:0]      dbits;
  logic            core_en;
  logic            mc_en;
  logic            bus_go;
  logic            bus_map;
  logic            slow_tick;
  logic [1:0]      op_class;
  logic [2:0]      op_group;
  logic [3:0]      op_low;

  always_comb begin
    n = r;
    ir = r.rom[r.pc];
    tword = r.rom[r.pc];
    op_class = ir[8:7];
    op_group = ir[6:4];
    op_low = ir[3:0];
    mem = r.ram[{r.x, r.y}];
    sum = 5'h00;
    sp_inc = r.sp + 2'h1;
    pc_inc = r.pc + 10'h001;
    in_page = {ir[2:0], r.d, r.a};
    dbits = {r.sync2.d7, r.pd[6:0]};
    // a held core freezes its dividers, so cycle phase resumes where it stopped
    slow_tick = (r.pre == CORE_DIV_LAST);
    core_en = r.run & (r.fast | slow_tick);
    mc_en = core_en & (r.mcnt == MC_DIV_LAST);
    bus_go = hsel & htrans[1] & hready;
    bus_map = (haddr[31:8] == 24'h000000);

    // key pins are asynchronous: nothing reads sync1 but sync2
    n.sync1 = pins_in;
    n.sync2 = r.sync1;
    n.bk1 = backup_return;
    n.bk2 = r.bk1;

    // prescaler turns only while running; fast mode pins it at zero
    if (r.run) begin
      n.pre = r.fast ? 3'h0 : r.pre + 3'h1;
    end
    if (core_en) begin
      n.mcnt = r.mcnt + 2'h1;
    end
    // the pulse trails the executed cycle by one clock
    n.mc_tick = mc_en;

    // reset aside, backup return is the only way this flag ever drops; a set op in
    // the same cycle still wins, as the decode below overrides this
    if (r.bk2) begin
      n.table_msb_enable = 1'b0;
    end

    if (mc_en) begin
      unique case (r.state)
        ST_EXEC: begin
          n.pc = pc_inc;
          if (r.skip) begin
            // skipped word costs one cycle, whatever it was
            n.skip = 1'b0;
          end else begin
            unique case (op_class)
              CL_P2CALL: begin
                n.sp = sp_inc;
                n.stk[sp_inc] = pc_inc;
                n.pc = {PAGE2, ir[6:0]};
              end
              CL_BRANCH: begin
                n.pc = {r.pc[PC_W-1:7], ir[6:0]};
              end
              CL_CALL: begin
                n.sp = sp_inc;
                n.stk[sp_inc] = pc_inc;
                n.pc = {r.pc[PC_W-1:7], ir[6:0]};
              end
              CL_BASIC: begin
                unique case (op_group)
                  G_MISC: begin
                    unique case (op_low)
                      OP_NOP: begin
                        n.pc = pc_inc;
                      end
                      OP_ADD_WITH_CARRY: begin
                        sum = {1'b0, r.a} + {1'b0, mem} + {4'h0, r.cy};
                        n.a = sum[3:0];
                        n.cy = sum[4];
                      end
                      OP_ADD_MEMORY: begin
                        n.a = r.a + mem;
                      end
                      OP_ROTATE_RIGHT: begin
                        n.a = {r.cy, r.a[3:1]};
                        n.cy = r.a[0];
                      end
                      OP_CARRY_SET: begin
                        n.cy = 1'b1;
                      end
                      OP_CARRY_CLEAR: begin
                        n.cy = 1'b0;
                      end
                      OP_TABLE_MSB_SET: begin
                        n.table_msb_enable = 1'b1;
                      end
                      OP_FAST_CLOCK: begin
                        // one-way: only reset brings back the slow clock
                        n.fast = 1'b1;
                      end
                      OP_RETURN: begin
                        n.pc = r.stk[r.sp];
                        n.sp = r.sp - 2'h1;
                        n.state = ST_SETTLE;
                      end
                      OP_RETURN_SKIP: begin
                        n.pc = r.stk[r.sp];
                        n.sp = r.sp - 2'h1;
                        n.skip = 1'b1;
                        n.state = ST_SETTLE;
                      end
                      OP_PAIR_STORE: begin
                        n.e = {r.b, r.a};
                      end
                      OP_PAIR_LOAD: begin
                        n.b = r.e[7:4];
                        n.a = r.e[3:0];
                      end
                      OP_PORT_SET_BIT: begin
                        n.pd[r.y[2:0]] = 1'b1;
                      end
                      OP_PORT_CLEAR_BIT: begin
                        n.pd[r.y[2:0]] = 1'b0;
                      end
                      OP_PORT_TEST_BIT: begin
                        n.skip = ~dbits[r.y[2:0]];
                      end
                      OP_PORT_CLEAR_ALL: begin
                        n.pd = 8'h00;
                      end
                    endcase
                  end
                  G_ADDI: begin
                    sum = {1'b0, r.a} + {1'b0, ir[3:0]};
                    n.a = sum[3:0];
                    n.skip = ~sum[4];
                  end
                  G_LDI: begin
                    n.a = ir[3:0];
                  end
                  G_SKEQ: begin
                    n.skip = (r.a == ir[3:0]);
                  end
                  G_PTR: begin
                    if (ir[3]) begin
                      n.x = ir[0];
                    end else begin
                      n.d = ir[2:0];
                    end
                  end
                  G_LDY: begin
                    n.y = ir[3:0];
                  end
                  G_TABLE: begin
                    if (ir[3]) begin
                      n.pc = in_page;
                    end else begin
                      // fetch borrows one stack entry for its return
                      n.sp = sp_inc;
                      n.stk[sp_inc] = pc_inc;
                      n.pc = in_page;
                      n.state = ST_TABLE_READ;
                    end
                  end
                  G_CALLMEM: begin
                    if (!ir[3]) begin
                      n.sp = sp_inc;
                      n.stk[sp_inc] = pc_inc;
                      n.pc = in_page;
                    end else begin
                      unique case (ir[2:0])
                        M_LOAD: begin
                          n.a = mem;
                        end
                        M_STORE: begin
                          n.ram[{r.x, r.y}] = r.a;
                        end
                        M_XCHG: begin
                          n.a = mem;
                          n.ram[{r.x, r.y}] = r.a;
                        end
                        M_A_TO_B: begin
                          n.b = r.a;
                        end
                        M_B_TO_A: begin
                          n.a = r.b;
                        end
                        M_IN_G: begin
                          n.a = r.sync2.g;
                        end
                        M_IN_E: begin
                          n.a = {1'b0, r.sync2.e};
                        end
                        M_PULLDOWN: begin
                          n.pu = r.a[2:0];
                        end
                      endcase
                    end
                  end
                endcase
              end
            endcase
          end
        end
        ST_TABLE_READ: begin
          // any word of any page is data here, bit 8 too when msb enable is set
          n.a = tword[3:0];
          n.b = tword[7:4];
          if (r.table_msb_enable) begin
            n.cy = tword[8];
          end
          n.pc = r.stk[r.sp];
          n.sp = r.sp - 2'h1;
          n.state = ST_SETTLE;
        end
        ST_SETTLE: begin
          n.state = ST_EXEC;
        end
      endcase
    end

    // e2 and the g nibble always wake; d7, e1, e0 only with pulldown on
    n.wake = 1'b0;
    if (r.sync2.e[2] || r.sync2.g != 4'h0) begin
      n.wake = 1'b1;
    end
    if ((r.sync2.d7 & r.pu[2]) || (r.sync2.e[1:0] & r.pu[1:0]) != 2'h0) begin
      n.wake = 1'b1;
    end

    // data phase of a write lands this cycle
    n.wr_pend = 1'b0;
    if (r.wr_pend) begin
      unique case (r.wr_addr)
        OFS_CTRL: begin
          n.run = hwdata[CTRL_RUN_BIT];
        end
        OFS_ROM_ADDR: begin
          n.rom_ptr = hwdata[PC_W-1:0];
        end
        OFS_ROM_DATA: begin
          n.rom[r.rom_ptr] = hwdata[8:0];
          // pointer wraps past the top word, so a long load restarts at 0
          n.rom_ptr = r.rom_ptr + 10'h001;
        end
        default: begin
          n.pc = n.pc;
        end
      endcase
    end

    // reads sample post-write values so back-to-back accesses agree
    if (bus_go) begin
      n.wr_pend = hwrite;
      n.wr_addr = bus_map ? haddr[7:0] : 8'hff;
    end
    // only a taken read moves the read word; writes leave it standing
    if (bus_go && !hwrite) begin
      n.rdata = 32'h00000000;
      if (bus_map) begin
        unique case (haddr[7:0])
          OFS_CTRL: begin
            n.rdata = {31'h00000000, n.run};
          end
          OFS_ROM_ADDR: begin
            n.rdata = {22'h000000, n.rom_ptr};
          end
          OFS_ROM_DATA: begin
            n.rdata = {23'h000000, n.rom[n.rom_ptr]};
          end
          OFS_STATUS: begin
            n.rdata = {8'h00, r.pc, r.sp, r.cy, r.table_msb_enable,
                       r.fast, r.skip, r.a, r.b};
          end
          OFS_PORT: begin
            n.rdata = {20'h00000, r.wake, r.pu, r.pd};
          end
          default: begin
            n.rdata = 32'h00000000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.pc <= PC_RESET;
      r.sp <= SP_RESET;
      r.state <= ST_EXEC;
      // zero wait states: the bus is ready from reset on
      r.ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign hreadyout = r.ready;
  // every transfer is answered okay, mapped or not
  assign hresp = r.wr_pend & 1'b0;
  assign hrdata = r.rdata;
  assign port_d_out = r.pd;
  assign pulldown_en = r.pu;
  assign wakeup = r.wake;
  assign machine_cycle = r.mc_tick;
endmodule

// *** sim/fbc_core_asserts.sv ***
// concurrent checks on the ports of the four-bit core
`timescale 1ns/1ps
module fbc_core_asserts
  import fbc_pkg::*;
(
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [2:0]            hsize,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [31:0]           hrdata,
  input wire fbc_pkg::fbc_pins_type pins_in,
  input wire logic                  backup_return,
  input wire logic [7:0]            port_d_out,
  input wire logic [2:0]            pulldown_en,
  input wire logic                  wakeup,
  input wire logic                  machine_cycle
);
  logic [5:0] gap_r;
  logic       seen_r;
  logic       rd_take;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  // saturating gap count, so a stopped core never wraps into a false pass
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_r  <= 6'h00;
      seen_r <= 1'b0;
    end else if (machine_cycle) begin
      gap_r  <= 6'h00;
      seen_r <= 1'b1;
    end else if (gap_r != 6'h3f) begin
      gap_r <= gap_r + 6'h01;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  zero_wait_a: assert property (hreadyout)
    else $error("slave inserted a wait state");
  okay_resp_a: assert property (!hresp)
    else $error("slave gave an error response");
  mc_pulse_a: assert property (machine_cycle |=> !machine_cycle)
    else $error("machine cycle pulse wider than one clock");
  mc_gap_a: assert property (machine_cycle && seen_r |->
    gap_r >= 6'h03 && gap_r <= 6'h1f)
    else $error("machine cycle spacing out of range");
  port_move_a: assert property ($changed(port_d_out) |->
    (machine_cycle || $past(machine_cycle)) or ##[1:2] machine_cycle)
    else $error("port latch moved outside a machine cycle");
  pd_move_a: assert property ($changed(pulldown_en) |->
    (machine_cycle || $past(machine_cycle)) or ##[1:2] machine_cycle)
    else $error("pulldown control moved outside a machine cycle");
  wake_on_a: assert property (
    (pins_in.g != 4'h0 || pins_in.e[2])[*4] |-> wakeup)
    else $error("always enabled key did not wake");
  wake_off_a: assert property ((pins_in == 8'h00)[*4] |-> !wakeup)
    else $error("wakeup with all keys low");
  rdata_hold_a: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (rd_take && haddr > 32'h10 |=>
    hrdata == 32'h0)
    else $error("unmapped read not zero");
  cover property (machine_cycle && gap_r == 6'h03);
  cover property (rd_take);
  cover property (wakeup);
endmodule
bind fbc_core fbc_core_asserts u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .pins_in(pins_in), .backup_return(backup_return),
  .port_d_out(port_d_out), .pulldown_en(pulldown_en), .wakeup(wakeup),
  .machine_cycle(machine_cycle));

// *** sim/fbc_port_model.sv ***
// port pins seen by the core: keys, open-drain drive and pull-downs
`timescale 1ns/1ps
module fbc_port_model
  import fbc_pkg::*;
(
  input  wire logic                  hclk,
  input  wire fbc_pkg::fbc_pins_type keys,
  input  wire logic [7:0]            port_d_out,
  input  wire logic [2:0]            pulldown_en,
  output fbc_pkg::fbc_pins_type      pins_in
);
  logic flt_r = 1'b0;
  // a pin with no pull-down floats: show a level that keeps changing
  always @(posedge hclk) flt_r <= !flt_r;
  always_comb begin
    pins_in.g    = keys.g;
    pins_in.e[2] = keys.e[2];
    pins_in.e[1] = keys.e[1] | (!pulldown_en[1] & flt_r);
    pins_in.e[0] = keys.e[0] | (!pulldown_en[0] & flt_r);
    pins_in.d7   = keys.d7 | port_d_out[7]
                 | (!pulldown_en[2] & flt_r);
  end
endmodule

// *** sim/fbc_core_tb.sv ***
// self-checking bench for the four-bit core
`timescale 1ns/1ps
module fbc_core_tb;
  import fbc_pkg::*;
  typedef struct packed {
    logic [0:7][8:0] p;
    logic [23:0]     e;
    logic [23:0]     m;
    logic [11:0]     pe;
  } fbc_row_type;
  localparam logic [8:0]  Z  = 9'h000;
  localparam logic [23:0] MF = 24'hfffeff;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic         hsel = 1'b0;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [2:0]   hsize = 3'h2;
  logic [31:0]  hwdata = 32'h0;
  logic         hready;
  logic         hreadyout;
  logic         hresp;
  logic [31:0]  hrdata;
  logic         backup_return = 1'b0;
  logic [7:0]   port_d_out;
  logic [2:0]   pulldown_en;
  logic         wakeup;
  logic         machine_cycle;
  fbc_pins_type keys = 8'h00;
  fbc_pins_type pins_in;
  logic [31:0]  q;
  logic [7:0]   kv [3] = '{8'h01, 8'h80, 8'h10};
  int           n_mismatch = 0;
  int           check_count = 0;
  fbc_row_type  rows [14];
  assign hready = hreadyout;
  always #25 hclk = !hclk;
  fbc_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pins_in(pins_in),
    .backup_return(backup_return), .port_d_out(port_d_out),
    .pulldown_en(pulldown_en), .wakeup(wakeup),
    .machine_cycle(machine_cycle));
  fbc_port_model model (.hclk(hclk), .keys(keys),
    .port_d_out(port_d_out), .pulldown_en(pulldown_en), .pins_in(pins_in));
  task end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic ok, input string s);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask
  task to_fail();
    n_mismatch++;
    $display("[FAIL] %0t wait ran out", $time);
    end_of_test();
  endtask
  task wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) to_fail();
  endtask
  // address phase held until hready, then data phase until hready
  task ahb(input logic w, input logic [15:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {16'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  // g returns the clocks between the last two machine cycle pulses
  task wait_mc(input int n, output int g);
    int c;
    int k;
    c = 0;
    k = 0;
    while (c < n && k < 1000) begin
      @(posedge hclk);
      k++;
      if (machine_cycle === 1'b1) begin
        c++;
        g = k;
        k = 0;
      end
    end
    if (c < n) to_fail();
  endtask
  task wait_wake(input logic v);
    int k;
    k = 0;
    while (wakeup !== v && k < 20) begin
      @(posedge hclk);
      k++;
    end
    if (wakeup !== v) to_fail();
  endtask
  // fresh reset per row: the program must start from address 0
  task run_row(input fbc_row_type r);
    int g;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1, OFS_ROM_ADDR, 32'h0);
    for (int i = 0; i < 8; i++) ahb(1, OFS_ROM_DATA, {23'h0, r.p[i]});
    ahb(1, OFS_ROM_DATA, 32'h108);
    ahb(1, OFS_ROM_ADDR, 32'h07f);
    ahb(1, OFS_ROM_DATA, 32'h029);
    ahb(1, OFS_ROM_DATA, 32'h100);
    ahb(1, OFS_ROM_DATA, 32'h000);
    ahb(1, OFS_ROM_DATA, 32'h1a5);
    ahb(1, OFS_ROM_ADDR, 32'h105);
    ahb(1, OFS_ROM_DATA, 32'h024);
    ahb(1, OFS_ROM_DATA, 32'h008);
    ahb(1, OFS_ROM_ADDR, 32'h3ff);
    ahb(1, OFS_ROM_DATA, 32'h1c3);
    ahb(1, OFS_CTRL, 32'h1);
    wait_mc(17, g);
    chk(g === (r.e[9] ? 4 : 32), "machine cycle period");
    ahb(0, OFS_STATUS, 32'h0);
    chk((q[23:0] & r.m) === (r.e & r.m), "core state");
    ahb(0, OFS_PORT, 32'h0);
    chk(q[11:0] === r.pe, "port state");
    chk({pulldown_en, port_d_out} === r.pe[10:0], "pins");
  endtask
  initial begin
    // e = {pc, sp, carry, msb enable, fast, skip, a, b}
    rows = '{
      '{{9'h029, 9'h018, {6{Z}}}, 24'h020010, MF, 12'h0},
      '{{9'h004, 9'h027, 9'h011, 9'h020, {4{Z}}}, 24'h020880, MF,
        12'h0},
      '{{9'h02f, 9'h079, 9'h004, 9'h001, {4{Z}}}, 24'h0208f0, MF,
        12'h0},
      '{{9'h025, 9'h004, 9'h005, 9'h003, {4{Z}}}, 24'h020800,
        24'hfffe0f, 12'h0},
      '{{9'h023, 9'h07b, 9'h026, 9'h00a, 9'h020, 9'h07b, 9'h00b, Z},
        24'h020063, MF, 12'h0},
      '{{9'h007, 9'h006, {6{Z}}}, 24'h020600, MF, 12'h0},
      '{{9'h022, 9'h040, 9'h006, 9'h061, {4{Z}}}, 24'h020c5a, MF,
        12'h0},
      '{{9'h02f, 9'h047, 9'h067, {5{Z}}}, 24'h02003c, MF,
        12'h0},
      '{{9'h085, {7{Z}}}, 24'h020040, MF, 12'h0},
      '{{9'h181, 9'h182, 9'h183, 9'h085, {4{Z}}}, 24'h023040, MF,
        12'h0},
      '{{9'h17f, {7{Z}}}, 24'h200090, MF, 12'h0},
      '{{9'h055, 9'h00c, 9'h052, 9'h00c, 9'h055, 9'h00d, 9'h025, 9'h07f},
        24'h020050, MF, 12'h504},
      '{{9'h024, 9'h07f, 9'h057, 9'h00e, 9'h061, {3{Z}}}, 24'h020040, MF,
        12'h400},
      '{{9'h027, 9'h07f, {6{Z}}}, 24'h020070, MF, 12'h700}};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(0, OFS_STATUS, 32'h0);
    chk(q === 32'h0, "status after reset");
    ahb(0, OFS_PORT, 32'h0);
    chk(q === 32'h0, "port after reset");
    ahb(1, 16'h0020, 32'hffff_ffff);
    ahb(0, 16'h0020, 32'h0);
    chk(q === 32'h0, "unmapped word");
    ahb(1, OFS_ROM_ADDR, 32'h010);
    ahb(1, OFS_ROM_DATA, 32'h1a5);
    ahb(1, OFS_ROM_ADDR, 32'h010);
    ahb(0, OFS_ROM_DATA, 32'h0);
    chk(q[8:0] === 9'h1a5, "rom word readback");
    $display("reset and map test done");
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    chk(wakeup === 1'b0, "wakeup with keys released");
    foreach (kv[i]) begin
      keys <= kv[i];
      wait_wake(1'b1);
      ahb(0, OFS_PORT, 32'h0);
      chk(q[11:8] === 4'hf, "key wakeup");
      keys <= 8'h00;
      wait_wake(1'b0);
    end
    $display("wakeup test done");
    run_row(rows[5]);
    backup_return <= 1'b1;
    repeat (4) @(posedge hclk);
    backup_return <= 1'b0;
    @(posedge hclk);
    ahb(0, OFS_STATUS, 32'h0);
    chk(q[10:9] === 2'b01, "msb enable after backup return");
    $display("backup return test done");
    end_of_test();
  end
endmodule
